/* flow_events_map.svh */
// Register offsets, field positions, reset values and event indices.
// Assumes a 32-bit AXI4-Lite slave with 8-bit byte addresses.
`ifndef FLOW_EVENTS_MAP_SVH
`define FLOW_EVENTS_MAP_SVH
`define OFS_CTRL 8'h00
`define OFS_THRESH 8'h04
`define OFS_SOFT 8'h08
`define OFS_TIMING 8'h0C
`define OFS_CMD 8'h10
`define OFS_RAW 8'h14
`define OFS_ENA 8'h18
`define OFS_MASKED 8'h1C
`define OFS_STATUS 8'h20
`define CTL_MANUAL_RTS 0
`define CTL_RX_FLOW 1
`define CTL_TX_FLOW 2
`define CTL_LOOPBACK 3
`define CTL_FORCE_PAUSE 4
`define CTL_FORCE_RESUME 5
`define CTL_SOFT_FLOW 6
`define CTL_SEND_PAUSE 7
`define CTL_SEND_RESUME 8
`define CTL_MULTIDROP 9
`define CTL_BREAK 10
`define CTL_DTR 11
`define F_RX_THR 0
`define F_RX_THR_HI 8
`define F_TX_EMPTY 16
`define F_PAUSE_CHAR 0
`define F_RESUME_CHAR 8
`define F_PAUSE_THR 16
`define F_RX_TOUT 0
`define F_IDLE_NUM 10
`define F_BRK_NUM 20
`define F_CMD_CHAR 0
`define F_CMD_NUM 8
`define CTRL_RST 32'h0000_0001
`define THRESH_RST 32'h0010_0070
`define SOFT_RST 32'h0070_1113
`define TIMING_RST 32'h00A0_280A
`define CMD_RST 32'h0000_032B
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define EV_CTS_CHG 0
`define EV_DSR_CHG 1
`define EV_PARITY 2
`define EV_FRAME 3
`define EV_MD_PARITY 4
`define EV_MD_FRAME 5
`define EV_COLLISION 6
`define EV_START_BIT 7
`define EV_PAUSE_RX 8
`define EV_RESUME_RX 9
`define EV_RX_TOUT 10
`define EV_BRK_DET 11
`define EV_RX_OVF 12
`define EV_TX_EMPTY 13
`define EV_RX_FULL 14
`define EV_TX_DONE 15
`define EV_BRK_SENT 16
`define EV_IDLE_DONE 17
`define EV_CMD_DET 18
`define EV_NUM 19
`endif

/* flow_events_pkg.sv */
// Types shared by the flow-control and event block.
// Assumes the transmit and receive cores sit outside this block.
package flow_events_pkg;
    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } axiReq_type;
    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axiRsp_type;
    typedef struct packed {
        logic byteValid;
        logic [7:0] rxByte;
        logic parityErr;
        logic frameErr;
        logic startBit;
        logic breakSeen;
        logic [9:0] fifoCount;
    } rxCore_type;
    typedef struct packed {
        logic txd;
        logic charDone;
        logic busy;
        logic [9:0] fifoCount;
        logic insertReady;
    } txCore_type;
    typedef enum logic [2:0] {
        BRK_IDLE = 3'b001,
        BRK_DRAIN = 3'b010,
        BRK_SEND = 3'b100
    } brkState_type;
endpackage : flow_events_pkg

/* remote_partner.sv */
// Remote serial device on the far side of the handshake pins.
// Assumes the bench sets the wanted handshake levels.
`timescale 1ns/1ns
module remote_partner (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic requestToSend,
    input wire logic wantSend,
    input wire logic ctsLevel,
    input wire logic dsrLevel,
    output logic clearToSendIn,
    output logic dataSetReadyIn,
    output logic serialRxIn
);
    logic [3:0] bitCnt_q;
    logic sending;
    assign clearToSendIn = ctsLevel;
    assign dataSetReadyIn = dsrLevel;
    assign sending = wantSend && requestToSend;
    // The line idles high, so a withheld sender shows no stale bits.
    assign serialRxIn = !sending || bitCnt_q[0];
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bitCnt_q <= 4'h0;
        end else if (sending) begin
            bitCnt_q <= bitCnt_q + 4'h1;
        end
    end
endmodule : remote_partner

/* uart_flow_events.sv */
// Flow control, loopback and event flags of the serial controller.
// Assumes the shifters and FIFOs outside report counts and pulses.
`timescale 1ns/1ns
`include "flow_events_map.svh"

// Overview of operation
// R1: Request line high invites the partner to send, low asks it to stop.
// R2: Without receive flow control the request line follows a control bit.
// R3: With receive flow control the request line drops above the threshold.
// R4: A clear-to-send edge raises an event; transmit halts after the char.
// R5: Terminal-ready output goes high when transmit data is prepared.
// R6: A data-set-ready edge raises an event; its level is readable.
// R7: Loopback ties transmit to receive and each handshake output to input.
// R8: Force pause stops the transmitter; force resume restarts it.
// R9: Soft flow sends the pause char once receive count passes threshold.
// R10: Send-pause and send-resume requests insert their char after the current.
// R11: Parity, frame and multidrop parity, frame and collision raise events.
// R12: A detected start bit raises its own event.
// R13: Received pause and resume chars raise their matching events.
// R14: A byte taking longer than the timeout raises the timeout event.
// R15: A low line where the stop bit belongs raises break detect.
// R16: A char arriving with the receive FIFO full raises overflow.
// R17: Transmit-empty is raised while transmit count is below threshold.
// R18: Receive-full compares count against high bits joined to base threshold.
// R19: Transmit-done is raised once the transmit FIFO has shifted out.
// R20: Break-sent follows the configured nulls after the FIFO drains.
// R21: Idle-done follows the minimum idle time after the last char.
// R22: The configured command char sequence raises command detect.
// R23: Events latch raw, enables gate one interrupt, write one clears.
module uart_flow_events #(
    parameter int unsigned RX_DEPTH = 128
) (
    input wire logic mclk,
    input wire logic rst_n,
    input flow_events_pkg::axiReq_type axiReq,
    output flow_events_pkg::axiRsp_type axiRsp,
    input wire logic serialRxIn,
    output logic serialTxOut,
    input wire logic clearToSendIn,
    input wire logic dataSetReadyIn,
    output logic requestToSend,
    output logic dataTermReady,
    input flow_events_pkg::rxCore_type rxCore,
    input flow_events_pkg::txCore_type txCore,
    output logic rxToCore,
    output logic txHalt,
    output logic insertValid,
    output logic [7:0] insertChar,
    output logic irq
);
    import flow_events_pkg::*;

    localparam logic [9:0] RX_FULL = 10'(RX_DEPTH);

    logic [31:0] ctrl_q, ctrl_d, thresh_q, soft_q, timing_q, cmd_q;
    logic [`EV_NUM-1:0] raw_q, raw_d, ena_q, ev, clrMask;
    logic bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q, rdMux;
    logic rts_q, dtr_q, halt_q, cts_q, dsr_q;
    logic remotePause_q, autoSent_q, pausePend_q, resumePend_q;
    brkState_type brk_q, brk_d;
    logic [7:0] nullCnt_q, cmdCnt_q;
    logic [9:0] toCnt_q, idleCnt_q;
    logic idleArm_q;
    logic [6:0] wrSel;
    logic wrOk, rdOk;

    // Control fields.
    wire manualRts = ctrl_q[`CTL_MANUAL_RTS];
    wire rxFlow = ctrl_q[`CTL_RX_FLOW];
    wire txFlow = ctrl_q[`CTL_TX_FLOW];
    wire loop = ctrl_q[`CTL_LOOPBACK];
    wire forcePause = ctrl_q[`CTL_FORCE_PAUSE];
    wire softEn = ctrl_q[`CTL_SOFT_FLOW];
    wire multidrop = ctrl_q[`CTL_MULTIDROP];
    wire breakEn = ctrl_q[`CTL_BREAK];
    wire [9:0] rxThr = {thresh_q[`F_RX_THR_HI +: 3],
        thresh_q[`F_RX_THR +: 7]};
    wire [9:0] txEmptyThr = thresh_q[`F_TX_EMPTY +: 10];
    wire [7:0] pauseChar = soft_q[`F_PAUSE_CHAR +: 8];
    wire [7:0] resumeChar = soft_q[`F_RESUME_CHAR +: 8];
    wire [9:0] pauseThr = soft_q[`F_PAUSE_THR +: 10];
    wire [9:0] rxTout = timing_q[`F_RX_TOUT +: 10];
    wire [9:0] idleNum = timing_q[`F_IDLE_NUM +: 10];
    wire [7:0] breakNum = timing_q[`F_BRK_NUM +: 8];
    wire [7:0] cmdChar = cmd_q[`F_CMD_CHAR +: 8];
    wire [7:0] cmdNum = cmd_q[`F_CMD_NUM +: 8];

    // Bus slave: address and data are taken together, one write at a time.
    wire wrGo = axiReq.awvalid & axiReq.wvalid & ~bvalid_q;
    wire rdGo = axiReq.arvalid & ~rvalid_q;
    wire [31:0] wmask = {{8{axiReq.wstrb[3]}}, {8{axiReq.wstrb[2]}},
        {8{axiReq.wstrb[1]}}, {8{axiReq.wstrb[0]}}};
    wire [31:0] wd = axiReq.wdata & wmask;

    always_comb begin
        wrSel = 7'h00;
        wrOk = 1'b1;
        if (axiReq.awaddr == `OFS_CTRL) begin
            wrSel[0] = 1'b1;
        end else if (axiReq.awaddr == `OFS_THRESH) begin
            wrSel[1] = 1'b1;
        end else if (axiReq.awaddr == `OFS_SOFT) begin
            wrSel[2] = 1'b1;
        end else if (axiReq.awaddr == `OFS_TIMING) begin
            wrSel[3] = 1'b1;
        end else if (axiReq.awaddr == `OFS_CMD) begin
            wrSel[4] = 1'b1;
        end else if (axiReq.awaddr == `OFS_RAW) begin
            wrSel[5] = 1'b1;
        end else if (axiReq.awaddr == `OFS_ENA) begin
            wrSel[6] = 1'b1;
        end else begin
            wrOk = 1'b0;
        end
    end

    wire [6:0] wrHit = wrSel & {7{wrGo}};
    wire [31:0] ctrlMerged = (ctrl_q & ~wmask) | wd;
    wire sendPauseReq = wrHit[0] & wd[`CTL_SEND_PAUSE];
    wire sendResumeReq = wrHit[0] & wd[`CTL_SEND_RESUME];
    wire forceResumeReq = wrHit[0] & wd[`CTL_FORCE_RESUME];

    // Handshake lines and loopback.
    wire ctsLevel = loop ? rts_q : clearToSendIn; // R7
    wire dsrLevel = loop ? dtr_q : dataSetReadyIn; // R7
    assign rxToCore = loop ? txCore.txd : serialRxIn; // R7
    // The pin is held idle in loopback so the partner sees no traffic.
    assign serialTxOut = loop ? 1'b1 : txCore.txd;
    wire ctsChg = ctsLevel ^ cts_q;
    wire dsrChg = dsrLevel ^ dsr_q;
    wire rxOver = rxCore.fifoCount > rxThr; // R18
    wire rtsNext = rxFlow ? ~rxOver : manualRts; // R2 R3

    // Software flow control.
    wire rxPauseChar = softEn & rxCore.byteValid &
        (rxCore.rxByte == pauseChar);
    wire rxResumeChar = softEn & rxCore.byteValid &
        (rxCore.rxByte == resumeChar);
    wire remotePause_d = rxPauseChar |
        (remotePause_q & ~rxResumeChar & ~forceResumeReq); // R8 R13
    wire pauseOver = rxCore.fifoCount > pauseThr;
    wire autoPause = softEn & pauseOver & ~autoSent_q; // R9
    wire autoResume = softEn & ~pauseOver & autoSent_q;
    wire nullValid = (brk_q == BRK_SEND) & (nullCnt_q != breakNum) &
        ~pausePend_q & ~resumePend_q;
    assign insertValid = pausePend_q | resumePend_q | nullValid; // R10
    assign insertChar = pausePend_q ? pauseChar :
        (resumePend_q ? resumeChar : 8'h00);
    wire take = insertValid & txCore.insertReady;
    wire takePause = take & pausePend_q;
    wire takeResume = take & ~pausePend_q & resumePend_q;
    wire takeNull = take & nullValid;
    wire brkDone = (brk_q == BRK_SEND) & (nullCnt_q == breakNum);

    always_comb begin
        brk_d = brk_q;
        case (brk_q)
            BRK_IDLE: begin
                if (breakEn) begin
                    brk_d = BRK_DRAIN;
                end
            end
            BRK_DRAIN: begin
                if (txCore.fifoCount == 10'h000 && !txCore.busy) begin
                    brk_d = BRK_SEND; // R20
                end
            end
            BRK_SEND: begin
                if (brkDone) begin
                    brk_d = BRK_IDLE;
                end
            end
            default: begin
                brk_d = BRK_IDLE;
            end
        endcase
    end

    always_comb begin
        ctrl_d = wrHit[0] ? ctrlMerged : ctrl_q;
        ctrl_d[`CTL_SEND_PAUSE] = 1'b0;
        ctrl_d[`CTL_SEND_RESUME] = 1'b0;
        ctrl_d[`CTL_FORCE_RESUME] = 1'b0;
        if (forceResumeReq) begin
            ctrl_d[`CTL_FORCE_PAUSE] = 1'b0; // R8
        end
        if (brkDone) begin
            ctrl_d[`CTL_BREAK] = 1'b0;
        end
    end

    // Receive timeout and command char counting.
    wire toRun = (rxCore.fifoCount != 10'h000) & ~rxCore.byteValid &
        (toCnt_q != rxTout);
    wire cmdMatch = rxCore.byteValid & (rxCore.rxByte == cmdChar);
    wire idleSeen = idleArm_q & ~txCore.busy &
        (txCore.fifoCount == 10'h000);

    // Event sources.
    assign ev[`EV_CTS_CHG] = ctsChg; // R4
    assign ev[`EV_DSR_CHG] = dsrChg; // R6
    assign ev[`EV_PARITY] = rxCore.parityErr; // R11
    assign ev[`EV_FRAME] = rxCore.frameErr; // R11
    assign ev[`EV_MD_PARITY] = multidrop & rxCore.parityErr; // R11
    assign ev[`EV_MD_FRAME] = multidrop & rxCore.frameErr; // R11
    assign ev[`EV_COLLISION] = multidrop & txCore.busy &
        (rxToCore != txCore.txd); // R11
    assign ev[`EV_START_BIT] = rxCore.startBit; // R12
    assign ev[`EV_PAUSE_RX] = rxPauseChar; // R13
    assign ev[`EV_RESUME_RX] = rxResumeChar; // R13
    assign ev[`EV_RX_TOUT] = toRun & (toCnt_q + 10'h001 == rxTout); // R14
    assign ev[`EV_BRK_DET] = rxCore.breakSeen; // R15
    assign ev[`EV_RX_OVF] = rxCore.byteValid &
        (rxCore.fifoCount >= RX_FULL); // R16
    assign ev[`EV_TX_EMPTY] = txCore.fifoCount < txEmptyThr; // R17
    assign ev[`EV_RX_FULL] = rxOver; // R18
    assign ev[`EV_TX_DONE] = txCore.charDone &
        (txCore.fifoCount == 10'h000); // R19
    assign ev[`EV_BRK_SENT] = brkDone; // R20
    assign ev[`EV_IDLE_DONE] = idleSeen & (idleCnt_q >= idleNum); // R21
    assign ev[`EV_CMD_DET] = cmdMatch &
        (cmdCnt_q + 8'h01 == cmdNum); // R22

    // A new event in the clearing cycle survives the clear.
    assign clrMask = wrHit[5] ? wd[`EV_NUM-1:0] : '0;
    assign raw_d = (raw_q & ~clrMask) | ev; // R23
    assign irq = |(raw_q & ena_q); // R23

    always_comb begin
        rdMux = 32'h0000_0000;
        rdOk = 1'b1;
        if (axiReq.araddr == `OFS_CTRL) begin
            rdMux = ctrl_q;
        end else if (axiReq.araddr == `OFS_THRESH) begin
            rdMux = thresh_q;
        end else if (axiReq.araddr == `OFS_SOFT) begin
            rdMux = soft_q;
        end else if (axiReq.araddr == `OFS_TIMING) begin
            rdMux = timing_q;
        end else if (axiReq.araddr == `OFS_CMD) begin
            rdMux = cmd_q;
        end else if (axiReq.araddr == `OFS_RAW) begin
            rdMux[`EV_NUM-1:0] = raw_q;
        end else if (axiReq.araddr == `OFS_ENA) begin
            rdMux[`EV_NUM-1:0] = ena_q;
        end else if (axiReq.araddr == `OFS_MASKED) begin
            rdMux[`EV_NUM-1:0] = raw_q & ena_q;
        end else if (axiReq.araddr == `OFS_STATUS) begin
            rdMux[3:0] = {halt_q, rts_q, ctsLevel, dsrLevel}; // R6
        end else begin
            rdOk = 1'b0;
        end
    end

    assign axiRsp.awready = wrGo;
    assign axiRsp.wready = wrGo;
    assign axiRsp.bvalid = bvalid_q;
    assign axiRsp.bresp = bresp_q;
    assign axiRsp.arready = ~rvalid_q;
    assign axiRsp.rvalid = rvalid_q;
    assign axiRsp.rresp = rresp_q;
    assign axiRsp.rdata = rdata_q;
    assign requestToSend = rts_q; // R1
    assign dataTermReady = dtr_q;
    assign txHalt = halt_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end else if (wrGo) begin
            bvalid_q <= 1'b1;
            bresp_q <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
        end else if (axiReq.bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rresp_q <= `RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (rdGo) begin
            rvalid_q <= 1'b1;
            rresp_q <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
            rdata_q <= rdMux;
        end else if (axiReq.rready) begin
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_q <= `CTRL_RST;
            thresh_q <= `THRESH_RST;
            soft_q <= `SOFT_RST;
            timing_q <= `TIMING_RST;
            cmd_q <= `CMD_RST;
            ena_q <= '0;
            raw_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            thresh_q <= wrHit[1] ? (thresh_q & ~wmask) | wd : thresh_q;
            soft_q <= wrHit[2] ? (soft_q & ~wmask) | wd : soft_q;
            timing_q <= wrHit[3] ? (timing_q & ~wmask) | wd : timing_q;
            cmd_q <= wrHit[4] ? (cmd_q & ~wmask) | wd : cmd_q;
            ena_q <= wrHit[6] ? wd[`EV_NUM-1:0] : ena_q;
            raw_q <= raw_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rts_q <= 1'b1;
            dtr_q <= 1'b0;
            halt_q <= 1'b0;
            // Track the pins in reset, so their idle level is no edge.
            cts_q <= ctsLevel;
            dsr_q <= dsrLevel;
        end else begin
            rts_q <= rtsNext; // R2 R3
            dtr_q <= ctrl_q[`CTL_DTR]; // R5
            halt_q <= forcePause | (txFlow & ~ctsLevel) |
                remotePause_d; // R4 R8
            cts_q <= ctsLevel;
            dsr_q <= dsrLevel;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            remotePause_q <= 1'b0;
            autoSent_q <= 1'b0;
            pausePend_q <= 1'b0;
            resumePend_q <= 1'b0;
        end else begin
            remotePause_q <= remotePause_d; // R8
            autoSent_q <= softEn & (autoPause | (autoSent_q & pauseOver));
            pausePend_q <= (pausePend_q & ~takePause) | autoPause |
                (softEn & sendPauseReq); // R9 R10
            resumePend_q <= (resumePend_q & ~takeResume) | autoResume |
                (softEn & sendResumeReq); // R10
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            brk_q <= BRK_IDLE;
            nullCnt_q <= 8'h00;
        end else begin
            brk_q <= brk_d;
            nullCnt_q <= (brk_q != BRK_SEND) ? 8'h00 :
                nullCnt_q + {7'h00, takeNull}; // R20
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            toCnt_q <= 10'h000;
            cmdCnt_q <= 8'h00;
            idleCnt_q <= 10'h000;
            idleArm_q <= 1'b0;
        end else begin
            toCnt_q <= toRun ? toCnt_q + 10'h001 :
                ((rxCore.byteValid | rxCore.fifoCount == 10'h000) ?
                10'h000 : toCnt_q); // R14
            if (rxCore.byteValid) begin
                cmdCnt_q <= cmdMatch ? cmdCnt_q + 8'h01 : 8'h00; // R22
            end
            idleArm_q <= txCore.charDone |
                (idleArm_q & ~ev[`EV_IDLE_DONE]); // R21
            idleCnt_q <= txCore.charDone ? 10'h000 :
                (idleSeen ? idleCnt_q + 10'h001 : idleCnt_q);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_rts_manual: assert property ( // R2
        !rxFlow |=> requestToSend == $past(manualRts))
        else $error("Request line does not follow the manual level.");
    chk_rts_full_drop: assert property ( // R3
        rxFlow && rxOver |=> !requestToSend)
        else $error("Request line stays high above the threshold.");
    chk_cts_change_event: assert property ( // R4
        ctsChg |=> raw_q[`EV_CTS_CHG])
        else $error("Clear-to-send edge did not set its event.");
    chk_cts_halt: assert property ( // R4
        txFlow && !ctsLevel |=> txHalt)
        else $error("Transmitter not halted with clear-to-send low.");
    chk_loop_handshake: assert property ( // R7
        loop && $changed(requestToSend) |-> ctsChg)
        else $error("Loopback does not carry the request line.");
    chk_force_pause: assert property ( // R8
        forcePause |=> txHalt)
        else $error("Force pause did not halt the transmitter.");
    chk_send_pause_char: assert property ( // R10
        softEn && sendPauseReq |=> insertValid &&
        insertChar == $past(pauseChar))
        else $error("Pause request did not present the pause char.");
    chk_pause_rx_event: assert property ( // R13
        rxPauseChar |=> raw_q[`EV_PAUSE_RX] && txHalt)
        else $error("Received pause char not flagged.");
    chk_overflow_event: assert property ( // R16
        rxCore.byteValid && rxCore.fifoCount == RX_FULL
        |=> raw_q[`EV_RX_OVF])
        else $error("Overflow not flagged.");
    chk_break_done: assert property ( // R20
        brkDone |=> raw_q[`EV_BRK_SENT] && brk_q == BRK_IDLE && !breakEn)
        else $error("Break completion not flagged.");
    chk_set_wins: assert property ( // R23
        ev != '0 |=> (raw_q & $past(ev)) == $past(ev))
        else $error("Event lost against a clear.");

    cov_break_sent: cover property (raw_q[`EV_BRK_SENT]);
    cov_auto_pause: cover property (autoPause ##[1:50] takePause);
    cov_irq_rise: cover property ($rose(irq));
endmodule : uart_flow_events

/* uart_flow_events_test.sv */
// Self-checking bench for the flow-control and event block.
// Assumes the partner model drives the handshake pins.
`timescale 1ns/1ns
`include "flow_events_map.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    miscompares++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module uart_flow_events_test;
    import flow_events_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    axiReq_type axiReq = '0;
    axiRsp_type axiRsp;
    rxCore_type rxCore = '0;
    txCore_type txCore = '0;
    logic serialRxIn, serialTxOut, clearToSendIn, dataSetReadyIn;
    logic requestToSend, dataTermReady, rxToCore, txHalt, insertValid, irq;
    logic ctsLevel = 1'b1;
    logic dsrLevel = 1'b0;
    logic [7:0] insertChar;
    logic [1:0] lastResp;
    logic [31:0] rv;
    logic [31:0] rstVal [5] = '{`CTRL_RST, `THRESH_RST, `SOFT_RST,
        `TIMING_RST, `CMD_RST};
    int evTab [4][3] = '{'{13, 2, 4}, '{12, 3, 5}, '{11, 7, 7},
        '{10, 11, 11}};
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    int thr;
    initial begin
        forever #20 mclk = !mclk;
    end
    uart_flow_events uart_flow_events_inst (.mclk(mclk), .rst_n(rst_n),
        .axiReq(axiReq), .axiRsp(axiRsp), .serialRxIn(serialRxIn),
        .serialTxOut(serialTxOut), .clearToSendIn(clearToSendIn),
        .dataSetReadyIn(dataSetReadyIn), .requestToSend(requestToSend),
        .dataTermReady(dataTermReady), .rxCore(rxCore), .txCore(txCore),
        .rxToCore(rxToCore), .txHalt(txHalt), .insertValid(insertValid),
        .insertChar(insertChar), .irq(irq));
    remote_partner remote_partner_inst (.mclk(mclk), .rst_n(rst_n),
        .requestToSend(requestToSend), .wantSend(1'b1),
        .ctsLevel(ctsLevel), .dsrLevel(dsrLevel),
        .clearToSendIn(clearToSendIn), .dataSetReadyIn(dataSetReadyIn),
        .serialRxIn(serialRxIn));
    task automatic complete_run();
        if (miscompares == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    // The run needs about three hundred cycles; this bounds every wait.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axiReq.awaddr <= a;
        axiReq.wdata <= d;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid <= 1'b1;
        axiReq.wstrb <= 4'hF;
        axiReq.bready <= 1'b1;
        @(posedge mclk iff axiRsp.awready && axiRsp.wready);
        axiReq.awvalid <= 1'b0;
        axiReq.wvalid <= 1'b0;
        @(posedge mclk iff axiRsp.bvalid);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        axiReq.araddr <= a;
        axiReq.arvalid <= 1'b1;
        axiReq.rready <= 1'b1;
        @(posedge mclk iff axiRsp.arready);
        axiReq.arvalid <= 1'b0;
        @(posedge mclk iff axiRsp.rvalid);
        d = axiRsp.rdata;
        lastResp = axiRsp.rresp;
    endtask : rd
    task automatic evChk(input int ev, input logic e);
        tick(2);
        rd(`OFS_RAW, rv);
        `CHK("raw event", e, rv[ev])
        wr(`OFS_RAW, 32'h0000_0001 << ev);
    endtask : evChk
    task automatic pulse(input int b, input logic [7:0] c, input int n);
        rxCore.rxByte <= c;
        tick(1);
        rxCore[b] <= 1'b1;
        tick(n);
        rxCore[b] <= 1'b0;
    endtask : pulse
    task automatic take();
        txCore.insertReady <= 1'b1;
        @(posedge mclk iff insertValid);
        txCore.insertReady <= 1'b0;
    endtask : take
    initial begin
        txCore.txd = 1'b1;
        txCore.fifoCount = 10'h3FF;
        void'($urandom(10));
        tick(8);
        rst_n <= 1'b1;
        tick(1);
        `CHK("request line", 1'b1, requestToSend)
        for (int i = 0; i < 7; i++) begin
            rd(8'(4 * i), rv);
            `CHK("reset value", (i < 5) ? rstVal[i] : 32'h0, rv)
        end
        rd(8'h24, rv);
        `CHK("unmapped resp", `RESP_SLVERR, lastResp)
        wr(`OFS_CTRL, 32'h0000_0800);
        tick(2);
        `CHK("request line", 1'b0, requestToSend)
        `CHK("terminal ready", 1'b1, dataTermReady)
        `CHK("withheld line", 1'b1, rxToCore)
        thr = $urandom_range(1000, 1);
        wr(`OFS_THRESH, 32'((thr / 128) * 256 + thr % 128));
        wr(`OFS_CTRL, 32'h0000_0003);
        for (int k = 0; k < 2; k++) begin
            rxCore.fifoCount <= 10'(thr + k);
            tick(12);
            `CHK("request line", 1'(k == 0), requestToSend)
            evChk(`EV_RX_FULL, 1'(k));
        end
        evChk(`EV_RX_TOUT, 1'b1);
        rxCore.fifoCount <= 10'h071;
        wr(`OFS_THRESH, `THRESH_RST);
        txCore.fifoCount <= 10'h00F;
        evChk(`EV_TX_EMPTY, 1'b1);
        txCore.fifoCount <= 10'h010;
        wr(`OFS_RAW, 32'h0000_2000);
        evChk(`EV_TX_EMPTY, 1'b0);
        for (int m = 0; m < 2; m++) begin
            wr(`OFS_CTRL, 32'(1 + 512 * m));
            foreach (evTab[i]) begin
                pulse(evTab[i][0], 8'h00, 1);
                evChk(evTab[i][1 + m], 1'b1);
            end
        end
        wr(`OFS_CTRL, 32'h0000_0041);
        tick(2);
        `CHK("insert char", 8'h13, insertChar)
        take();
        rxCore.fifoCount <= 10'h000;
        tick(3);
        `CHK("insert char", 8'h11, insertChar)
        take();
        for (int j = 0; j < 2; j++) begin
            wr(`OFS_CTRL, 32'h0000_0041 | (32'h0000_0080 << j));
            tick(2);
            `CHK("insert char", (j == 0) ? 8'h13 : 8'h11, insertChar)
            take();
        end
        wr(`OFS_CTRL, 32'h0000_0001);
        wr(`OFS_CTRL, 32'h0000_0081);
        tick(2);
        `CHK("insert pending", 1'b0, insertValid)
        wr(`OFS_CTRL, 32'h0000_0041);
        pulse(22, 8'h13, 1);
        evChk(`EV_PAUSE_RX, 1'b1);
        `CHK("halt", 1'b1, txHalt)
        pulse(22, 8'h11, 1);
        evChk(`EV_RESUME_RX, 1'b1);
        `CHK("halt", 1'b0, txHalt)
        pulse(22, 8'h2B, 3);
        evChk(`EV_CMD_DET, 1'b1);
        rxCore.fifoCount <= 10'd128;
        pulse(22, 8'h41, 1);
        evChk(`EV_RX_OVF, 1'b1);
        wr(`OFS_CTRL, 32'h0000_0005);
        ctsLevel <= 1'b0;
        evChk(`EV_CTS_CHG, 1'b1);
        `CHK("halt", 1'b1, txHalt)
        ctsLevel <= 1'b1;
        dsrLevel <= 1'b1;
        evChk(`EV_DSR_CHG, 1'b1);
        rd(`OFS_STATUS, rv);
        `CHK("dsr level", 1'b1, rv[0])
        `CHK("halt", 1'b0, txHalt)
        for (int j = 0; j < 2; j++) begin
            wr(`OFS_CTRL, 32'h0000_0011 << j);
            tick(2);
            `CHK("halt", 1'(j == 0), txHalt)
        end
        txCore.fifoCount <= 10'h000;
        txCore.charDone <= 1'b1;
        tick(1);
        txCore.charDone <= 1'b0;
        evChk(`EV_TX_DONE, 1'b1);
        tick(4);
        evChk(`EV_IDLE_DONE, 1'b1);
        txCore.insertReady <= 1'b1;
        wr(`OFS_CTRL, 32'h0000_0400);
        tick(12);
        evChk(`EV_BRK_SENT, 1'b1);
        txCore.insertReady <= 1'b0;
        wr(`OFS_CTRL, 32'h0000_0009);
        for (int j = 0; j < 4; j++) begin
            txCore.txd <= 1'($urandom);
            tick(2);
            `CHK("loop data", txCore.txd, rxToCore)
            `CHK("tx pin", 1'b1, serialTxOut)
        end
        rd(`OFS_STATUS, rv);
        `CHK("loop levels", 2'b10, rv[1:0])
        wr(`OFS_ENA, 32'h0000_0004);
        pulse(13, 8'h00, 1);
        tick(2);
        `CHK("irq", 1'b1, irq)
        wr(`OFS_RAW, 32'h0000_0004);
        tick(2);
        `CHK("irq", 1'b0, irq)
        complete_run();
    end
endmodule : uart_flow_events_test
